/* rtl/tfo_pkg.sv */
package tfo_pkg;

    // frame geometry: blocks of one overhead bit followed by payload
    localparam int          TFO_BLOCK_BITS  = 85;
    localparam int          TFO_BLOCKS      = 56;
    localparam int          TFO_OH_BITS     = 1;
    localparam int          TFO_LEAD        = 3;
    localparam int          TFO_FRAC_PERIOD = 8;
    localparam int          TFO_FRAC_OH     = 1;
    localparam int          TFO_BYTE_W      = 8;
    localparam int          TFO_POS_W       = 7;
    localparam int          TFO_IDX_W       = 6;
    localparam int          TFO_FRC_W       = 8;
    localparam int          TFO_CNT_W       = 4;
    localparam int          TFO_PIPE_W      = 3;
    localparam logic [3:0]  TFO_BYTE_LAST   = 4'h7;

    // framing mode, gray along nonfrac, plcp, flex, ext, int
    typedef enum logic [2:0] {
        TFO_MODE_NONFRAC = 3'h0,
        TFO_MODE_PLCP    = 3'h1,
        TFO_MODE_FLEX    = 3'h3,
        TFO_MODE_EXT     = 3'h2,
        TFO_MODE_INT     = 3'h6
    } tfo_mode_e;

    // reference clock selection
    typedef enum logic [1:0] {
        TFO_REF_TXIN  = 2'h0,
        TFO_REF_TXOUT = 2'h1,
        TFO_REF_RXOUT = 2'h3,
        TFO_REF_RXLN  = 2'h2
    } tfo_ref_e;

    // function of the shared frame pin
    typedef enum logic {
        TFO_FN_START  = 1'h0,
        TFO_FN_WINDOW = 1'h1
    } tfo_fn_e;

    // static port configuration
    typedef struct packed {
        logic      pins_en;
        tfo_mode_e mode;
        tfo_fn_e   fn;
        logic      inv_mark;
        logic      inv_valid;
        logic      inv_bit;
    } tfo_cfg_s;

endpackage

/* rtl/tfo_sync.sv */
// two-flop level synchroniser, one vector
module tfo_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    import tfo_pkg::*;

    logic [2*W-1:0] st_q;
    logic [2*W-1:0] st_d;

    // first stage feeds only the second
    always_comb begin
        st_d = {st_q[W-1:0], d};
    end

    always_ff @(posedge clk) begin
        st_q <= st_d;
    end

    assign q = st_q[2*W-1:W];
endmodule

/* rtl/tfo_pay_xfer.sv */
// byte handshake from the system clock to the link clock
module tfo_pay_xfer (
    input  wire logic                           clk,
    input  wire logic                           rst,
    input  wire logic                           link_clk,
    input  wire logic                           link_rst,
    input  wire logic [tfo_pkg::TFO_BYTE_W-1:0] pay_data,
    input  wire logic                           pay_valid,
    output logic                                pay_ready,
    input  wire logic                           take,
    output logic      [tfo_pkg::TFO_BYTE_W-1:0] buf_data,
    output logic                                buf_full
);
    import tfo_pkg::*;

    typedef struct packed {
        logic                  want;
        logic                  ack;
        logic                  req_prev;
        logic [TFO_BYTE_W-1:0] hold;
    } tfo_sys_s;

    typedef struct packed {
        logic                  req;
        logic                  pending;
        logic                  full;
        logic                  ack_prev;
        logic [TFO_BYTE_W-1:0] data;
    } tfo_lnk_s;

    tfo_sys_s s_q;
    tfo_sys_s s_d;
    tfo_lnk_s l_q;
    tfo_lnk_s l_d;
    logic     req_s;
    logic     ack_s;

    tfo_sync #(.W(1)) u_req_sync (.clk(clk), .d(l_q.req), .q(req_s));
    tfo_sync #(.W(1)) u_ack_sync (.clk(link_clk), .d(s_q.ack), .q(ack_s));

    // system side: a request edge opens a slot for one byte
    always_comb begin
        s_d = s_q;
        s_d.req_prev = req_s;
        if (req_s != s_q.req_prev) begin
            s_d.want = 1'b1;
        end
        if (s_q.want && pay_valid) begin
            s_d.hold = pay_data;
            s_d.ack  = ~s_q.ack;
            s_d.want = 1'b0;
        end
        if (rst) begin
            s_d = '0;
        end
    end

    always_ff @(posedge clk) begin
        s_q <= s_d;
    end

    assign pay_ready = s_q.want;

    // link side: keep one byte staged ahead of the shifter
    always_comb begin
        l_d = l_q;
        l_d.ack_prev = ack_s;
        if (!l_q.full && !l_q.pending) begin
            l_d.req     = ~l_q.req;
            l_d.pending = 1'b1;
        end
        if (ack_s != l_q.ack_prev) begin
            l_d.data    = s_q.hold;    // held stable until the next request
            l_d.full    = 1'b1;
            l_d.pending = 1'b0;
        end
        if (take) begin
            l_d.full = 1'b0;
        end
        if (link_rst) begin
            l_d = '0;
        end
    end

    always_ff @(posedge link_clk) begin
        l_q <= l_d;
    end

    assign buf_data = l_q.data;
    assign buf_full = l_q.full;
endmodule

/* rtl/tfo_port_timing.sv */
// What this block does
// - With start function and pins on in external, flex or nonfractional modes, the pin marks frame start.
// - The start pulse is one reference clock high, three clocks before the frame's first overhead bit.
// - With window function and pins on, the pin marks frame payload bits in those same modes.
// - The window rises three reference clocks before the first payload bit of a block.
// - The window falls three reference clocks before the last payload bit ends, tracking payload.
// - Start and window share one pin, the configured one is driven in those modes, and neither without pins on.
// - In internal fractional mode with pins on the pin marks fractional overhead payload positions.
// - In flex mode with pins on the payload bit output carries processor payload bits.
// - Payload valid is high exactly in the cycles where the payload bit is valid.
// - Outputs change on the rising reference edge, or the falling one when the clock is inverted.
// - The reference clock defaults to the transmit clock input, or one of three others by selection.
// - The frame pin, payload valid and payload bit polarities can each be inverted on its own.
// - In flex mode with pins on payload valid follows the payload enable input three clocks later.
// - The gapped clock is the reference clock gated by the active window or overhead mark.
module tfo_port_timing (
    input  wire logic                           clk,
    input  wire logic                           rst,
    input  wire tfo_pkg::tfo_cfg_s              cfg,
    input  wire tfo_pkg::tfo_ref_e              ref_sel,
    input  wire logic                           ref_clk_invert,
    input  wire logic                           tx_clock_input,
    input  wire logic                           tx_clock_output,
    input  wire logic                           rx_clock_output,
    input  wire logic                           rx_line_clock,
    input  wire logic [tfo_pkg::TFO_BYTE_W-1:0] pay_data,
    input  wire logic                           pay_valid,
    output logic                                pay_ready,
    input  wire logic                           tx_payload_enable_in,
    output logic                                tx_frame_mux_out,
    output logic                                tx_payload_valid_out,
    output logic                                tx_payload_bit_out,
    output logic                                tx_gapped_clock
);
    import tfo_pkg::*;

    localparam logic [TFO_POS_W-1:0] POS_LAST  = TFO_POS_W'(TFO_BLOCK_BITS - 1);
    localparam logic [TFO_POS_W-1:0] POS_PAY   = TFO_POS_W'(TFO_OH_BITS);
    localparam logic [TFO_IDX_W-1:0] IDX_LAST  = TFO_IDX_W'(TFO_BLOCKS - 1);
    localparam logic [TFO_FRC_W-1:0] FRC_LAST  = TFO_FRC_W'(TFO_FRAC_PERIOD - 1);
    localparam logic [TFO_FRC_W-1:0] FRC_OH    = TFO_FRC_W'(TFO_FRAC_OH);

    // link-domain state
    typedef struct packed {
        logic [TFO_POS_W-1:0]  pos;
        logic [TFO_IDX_W-1:0]  idx;
        logic [TFO_FRC_W-1:0]  frc;
        logic                  start;
        logic                  window;
        logic                  fmark;
        logic [TFO_PIPE_W-1:0] en_pipe;
        logic [TFO_BYTE_W-1:0] sh;
        logic [TFO_CNT_W-1:0]  left;
        logic                  pin_mark;
        logic                  pin_valid;
        logic                  pin_bit;
    } tfo_link_s;

    tfo_link_s             l_q;
    tfo_link_s             l_d;
    tfo_cfg_s              cfg_l;
    logic                  ref_mux;
    logic                  link_clk;
    logic                  lrst;
    logic                  take;
    logic [TFO_BYTE_W-1:0] buf_data;
    logic                  buf_full;
    logic                  gate_q;
    logic                  frac_mode;
    logic                  flex_on;

    // reference clock choice; ref_sel is static and changed only in reset
    always_comb begin
        case (ref_sel)
            TFO_REF_TXIN:  ref_mux = tx_clock_input;
            TFO_REF_TXOUT: ref_mux = tx_clock_output;
            TFO_REF_RXOUT: ref_mux = rx_clock_output;
            TFO_REF_RXLN:  ref_mux = rx_line_clock;
            default:       ref_mux = tx_clock_input;
        endcase
    end

    // inverting the clock moves every update to the opposite reference edge
    assign link_clk = ref_mux ^ ref_clk_invert;

    // reset and configuration into the link domain
    tfo_sync #(.W(1)) u_rst_sync (
        .clk (link_clk),
        .d   (rst),
        .q   (lrst)
    );

    tfo_sync #(.W($bits(tfo_cfg_s))) u_cfg_sync (
        .clk (link_clk),
        .d   (cfg),
        .q   (cfg_l)
    );

    // payload bytes from the system side
    tfo_pay_xfer u_xfer (
        .clk       (clk),
        .rst       (rst),
        .link_clk  (link_clk),
        .link_rst  (lrst),
        .pay_data  (pay_data),
        .pay_valid (pay_valid),
        .pay_ready (pay_ready),
        .take      (take),
        .buf_data  (buf_data),
        .buf_full  (buf_full)
    );

    assign frac_mode = (cfg_l.mode == TFO_MODE_INT);
    assign flex_on   = cfg_l.pins_en && (cfg_l.mode == TFO_MODE_FLEX);

    // frame timing, shared pin and payload serialiser
    always_comb begin
        l_d  = l_q;
        take = 1'b0;
        // position counter runs three bits ahead of the input data
        if (l_q.pos == POS_LAST) begin
            l_d.pos = '0;
            l_d.idx = (l_q.idx == IDX_LAST) ? '0 : l_q.idx + 1'b1;
        end else begin
            l_d.pos = l_q.pos + 1'b1;
        end
        l_d.start  = (l_q.pos == '0) && (l_q.idx == '0);
        l_d.window = (l_q.pos >= POS_PAY);
        // fractional overhead positions counted over payload bits
        l_d.fmark = l_d.window && (l_q.frc < FRC_OH);
        if (l_d.start) begin
            l_d.frc = '0;
        end else if (l_d.window) begin
            l_d.frc = (l_q.frc == FRC_LAST) ? '0 : l_q.frc + 1'b1;
        end
        // shared pin: function picked by mode and select
        l_d.pin_mark = cfg_l.inv_mark;
        if (cfg_l.pins_en) begin
            case (cfg_l.mode)
                TFO_MODE_INT: begin
                    l_d.pin_mark = l_d.fmark ^ cfg_l.inv_mark;
                end
                TFO_MODE_EXT, TFO_MODE_FLEX, TFO_MODE_NONFRAC: begin
                    if (cfg_l.fn == TFO_FN_WINDOW) begin
                        l_d.pin_mark = l_d.window ^ cfg_l.inv_mark;
                    end else begin
                        l_d.pin_mark = l_d.start ^ cfg_l.inv_mark;
                    end
                end
                default: begin
                    l_d.pin_mark = cfg_l.inv_mark;
                end
            endcase
        end
        // payload enable delayed three clocks
        l_d.en_pipe   = {l_q.en_pipe[TFO_PIPE_W-2:0], tx_payload_enable_in};
        l_d.pin_valid = cfg_l.inv_valid;
        l_d.pin_bit   = cfg_l.inv_bit;
        if (flex_on && l_q.en_pipe[TFO_PIPE_W-1]) begin
            l_d.pin_valid = ~cfg_l.inv_valid;
            if (l_q.left == '0) begin
                // underrun sends zero and keeps the shifter empty
                if (buf_full) begin
                    take        = 1'b1;
                    l_d.pin_bit = buf_data[TFO_BYTE_W-1] ^ cfg_l.inv_bit;
                    l_d.sh      = {buf_data[TFO_BYTE_W-2:0], 1'b0};
                    l_d.left    = TFO_BYTE_LAST;
                end
            end else begin
                l_d.pin_bit = l_q.sh[TFO_BYTE_W-1] ^ cfg_l.inv_bit;
                l_d.sh      = {l_q.sh[TFO_BYTE_W-2:0], 1'b0};
                l_d.left    = l_q.left - 1'b1;
            end
        end
        if (lrst) begin
            l_d          = '0;
            l_d.en_pipe  = {l_q.en_pipe[TFO_PIPE_W-2:0], tx_payload_enable_in};
            l_d.pin_mark = cfg_l.inv_mark;
            l_d.pin_valid = cfg_l.inv_valid;
            l_d.pin_bit  = cfg_l.inv_bit;
            take         = 1'b0;
        end
    end

    always_ff @(posedge link_clk) begin
        l_q <= l_d;
    end

    assign tx_frame_mux_out     = l_q.pin_mark;
    assign tx_payload_valid_out = l_q.pin_valid;
    assign tx_payload_bit_out   = l_q.pin_bit;

    // gate enable moves while the clock is low, so the gated clock never glitches
    always_ff @(negedge link_clk) begin
        if (lrst || !cfg_l.pins_en || cfg_l.mode == TFO_MODE_PLCP) begin
            gate_q <= 1'b0;
        end else begin
            gate_q <= frac_mode ? l_q.fmark : l_q.window;
        end
    end

    assign tx_gapped_clock = link_clk & gate_q;

    // multi-step shapes of the frame timing
    sequence win_hold_s;
        l_q.window [*8];
    endsequence

    sequence flex_run_s;
        flex_on [*5];
    endsequence

    sof_single_a: assert property (@(posedge link_clk) disable iff (lrst)
        l_q.start |=> !l_q.start [*8])
        else $error("start pulse longer than one clock");

    sof_overhead_a: assert property (@(posedge link_clk) disable iff (lrst)
        l_q.start |-> !l_q.window ##1 l_q.window)
        else $error("start pulse not aligned to overhead bit");

    win_gap_a: assert property (@(posedge link_clk) disable iff (lrst)
        $fell(l_q.window) |=> l_q.window)
        else $error("window gap not one overhead bit");

    win_open_a: assert property (@(posedge link_clk) disable iff (lrst)
        $rose(l_q.window) |-> win_hold_s)
        else $error("window closed early");

    pin_idle_a: assert property (@(posedge link_clk) disable iff (lrst)
        (!cfg_l.pins_en && $stable(cfg_l)) |=> (tx_frame_mux_out == cfg_l.inv_mark))
        else $error("frame pin active with pins off");

    pin_window_a: assert property (@(posedge link_clk) disable iff (lrst)
        (cfg_l.pins_en && cfg_l.mode == TFO_MODE_EXT && cfg_l.fn == TFO_FN_WINDOW
         && $stable(cfg_l))
        |=> (tx_frame_mux_out == (l_q.window ^ cfg_l.inv_mark)))
        else $error("frame pin not showing window");

    pin_frac_a: assert property (@(posedge link_clk) disable iff (lrst)
        (cfg_l.pins_en && frac_mode && $stable(cfg_l))
        |=> (tx_frame_mux_out == (l_q.fmark ^ cfg_l.inv_mark)))
        else $error("frame pin not showing overhead mark");

    valid_delay_a: assert property (@(posedge link_clk) disable iff (lrst)
        flex_run_s |-> (tx_payload_valid_out
                        == ($past(tx_payload_enable_in, 4) ^ cfg_l.inv_valid)))
        else $error("payload valid not three clocks after enable");

    bit_quiet_a: assert property (@(posedge link_clk) disable iff (lrst)
        ($stable(cfg_l) && tx_payload_valid_out == cfg_l.inv_valid)
        |-> (tx_payload_bit_out == cfg_l.inv_bit))
        else $error("payload bit moves outside valid");

    flex_idle_a: assert property (@(posedge link_clk) disable iff (lrst)
        (!flex_on && $stable(cfg_l)) |=> (tx_payload_valid_out == cfg_l.inv_valid))
        else $error("payload valid active outside flex");

    // start function on the shared pin in nonfractional framing
    pin_start_a: assert property (@(posedge link_clk) disable iff (lrst)
        (cfg_l.pins_en && cfg_l.mode == TFO_MODE_NONFRAC && cfg_l.fn == TFO_FN_START
         && $stable(cfg_l))
        |=> (tx_frame_mux_out == (l_q.start ^ cfg_l.inv_mark)))
        else $error("frame pin not showing start pulse");

    plcp_quiet_a: assert property (@(posedge link_clk) disable iff (lrst)
        (cfg_l.pins_en && cfg_l.mode == TFO_MODE_PLCP && $stable(cfg_l))
        |=> (tx_frame_mux_out == cfg_l.inv_mark))
        else $error("frame pin active in plcp mode");

    // overhead marks only ever fall on payload positions
    fmark_in_win_a: assert property (@(posedge link_clk) disable iff (lrst)
        l_q.fmark |-> l_q.window)
        else $error("overhead mark outside payload");

    // the shifter only pulls a byte that is staged
    take_staged_a: assert property (@(posedge link_clk) disable iff (lrst)
        take |-> buf_full)
        else $error("payload byte taken from empty stage");

    // gapped clock enable: shut with pins off or in plcp mode, else the active mark
    gate_off_a: assert property (@(posedge link_clk) disable iff (lrst)
        (!cfg_l.pins_en && $stable(cfg_l)) |=> !gate_q)
        else $error("gapped clock running with pins off");

    gate_window_a: assert property (@(posedge link_clk) disable iff (lrst)
        (cfg_l.pins_en && cfg_l.mode == TFO_MODE_EXT && $stable(cfg_l))
        |=> (gate_q == l_q.window))
        else $error("gapped clock not following window");

    gate_frac_a: assert property (@(posedge link_clk) disable iff (lrst)
        (cfg_l.pins_en && frac_mode && $stable(cfg_l))
        |=> (gate_q == l_q.fmark))
        else $error("gapped clock not following overhead mark");

endmodule

/* test/tfo_far_end.sv */
// payload consumer on the far side of the transmit port
module tfo_far_end (
    input  wire logic        rc,
    input  wire logic        run,
    input  wire logic        inv_valid,
    input  wire logic        inv_bit,
    input  wire logic        tx_payload_valid_out,
    input  wire logic        tx_payload_bit_out,
    output logic             tx_payload_enable_in,
    output logic [31:0]      word,
    output int               nbits,
    output int               bad,
    output int               chk
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] hist;
    int         ph;

    initial begin
        tx_payload_enable_in = 1'h0;
        word = 32'h0;
        nbits = 0;
        bad = 0;
        chk = 0;
        hist = 4'h0;
        ph = 0;
    end

    // gapped enable pattern, five on and three off, moved just after the update edge
    always @(posedge rc) begin
        ph <= (ph + 1) % 8;
        tx_payload_enable_in <= #1 run && (ph < 5);
    end

    // valid trails the enable by three update edges; bits kept only while valid
    always @(negedge rc) begin
        if (run) begin
            chk++;
            if (tx_payload_valid_out !== (hist[3] ^ inv_valid)) begin
                bad++;
                $display("BAD at %0t: payload valid out of step with enable", $time);
            end
            if ((tx_payload_valid_out ^ inv_valid) === 1'h1 && nbits < 32) begin
                word = {word[30:0], tx_payload_bit_out ^ inv_bit};
                nbits++;
            end
        end
        hist = {hist[2:0], tx_payload_enable_in};
    end
endmodule

/* test/testbench.sv */
// transmit port timing bench
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import tfo_pkg::*;

    logic                  clk, rst, ref_clk_invert, rc, run, mk_w;
    logic                  tx_clock_input, tx_clock_output, rx_clock_output, rx_line_clock;
    tfo_cfg_s              cfg;
    tfo_ref_e              ref_sel;
    logic [TFO_BYTE_W-1:0] pay_data;
    logic                  pay_valid, pay_ready, tx_payload_enable_in, tx_frame_mux_out;
    logic                  tx_payload_valid_out, tx_payload_bit_out, tx_gapped_clock;
    logic [31:0]           word;
    int                    nbits, far_bad, far_chk, gcnt, err_count, n_tests;

    // system clock and four unrelated reference clocks
    initial begin clk = 1'h0; forever #2 clk = ~clk; end
    initial begin tx_clock_input = 1'h0; #7; forever #16 tx_clock_input = ~tx_clock_input; end
    initial begin tx_clock_output = 1'h0; #3; forever #18 tx_clock_output = ~tx_clock_output; end
    initial begin rx_clock_output = 1'h0; #11; forever #20 rx_clock_output = ~rx_clock_output; end
    initial begin rx_line_clock = 1'h0; #5; forever #22 rx_line_clock = ~rx_line_clock; end

    // update edge of the selected reference, as the outputs should follow it
    always_comb begin
        case (ref_sel)
            TFO_REF_TXOUT: rc = tx_clock_output ^ ref_clk_invert;
            TFO_REF_RXOUT: rc = rx_clock_output ^ ref_clk_invert;
            TFO_REF_RXLN:  rc = rx_line_clock ^ ref_clk_invert;
            default:       rc = tx_clock_input ^ ref_clk_invert;
        endcase
    end
    assign mk_w = tx_frame_mux_out ^ cfg.inv_mark;
    always @(posedge tx_gapped_clock) gcnt++;

    tfo_port_timing i_dut (
        .clk(clk), .rst(rst), .cfg(cfg), .ref_sel(ref_sel), .ref_clk_invert(ref_clk_invert),
        .tx_clock_input(tx_clock_input), .tx_clock_output(tx_clock_output),
        .rx_clock_output(rx_clock_output), .rx_line_clock(rx_line_clock),
        .pay_data(pay_data), .pay_valid(pay_valid), .pay_ready(pay_ready),
        .tx_payload_enable_in(tx_payload_enable_in), .tx_frame_mux_out(tx_frame_mux_out),
        .tx_payload_valid_out(tx_payload_valid_out), .tx_payload_bit_out(tx_payload_bit_out),
        .tx_gapped_clock(tx_gapped_clock)
    );

    tfo_far_end i_far (
        .rc(rc), .run(run), .inv_valid(cfg.inv_valid), .inv_bit(cfg.inv_bit),
        .tx_payload_valid_out(tx_payload_valid_out), .tx_payload_bit_out(tx_payload_bit_out),
        .tx_payload_enable_in(tx_payload_enable_in), .word(word), .nbits(nbits),
        .bad(far_bad), .chk(far_chk)
    );

    // verdict and end of run
    task automatic report_and_stop();
        err_count += far_bad;
        n_tests += far_chk;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic give_up(input string what);
        err_count++;
        $display("BAD at %0t: timeout %s", $time, what);
        report_and_stop();
    endtask

    task automatic cmp(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("BAD at %0t: bit got %b expected %b", $time, got, exp);
        end
    endtask

    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("BAD at %0t: word got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic tfo_cfg_s mk(logic p, tfo_mode_e m, tfo_fn_e f, logic a, logic b, logic c);
        mk = '{p, m, f, a, b, c};
    endfunction

    // reset with a new setup; outputs must sit at their inactive levels meanwhile
    task automatic restart(input tfo_cfg_s c, input tfo_ref_e r, input logic inv);
        @(negedge clk);
        rst = 1'h1;
        cfg = c;
        ref_sel = r;
        ref_clk_invert = inv;
        repeat (50) @(negedge clk);
        cmp(tx_frame_mux_out, c.inv_mark);
        cmp(tx_payload_valid_out, c.inv_valid);
        cmp(tx_payload_bit_out, c.inv_bit);
        rst = 1'h0;
    endtask

    // offer one byte and hold it until the edge that takes it
    task automatic put_byte(input logic [TFO_BYTE_W-1:0] b);
        int w;
        w = 0;
        @(negedge clk);
        pay_valid = 1'h1;
        pay_data = b;
        // ready stands until taken, so the next rising edge takes the byte
        while (pay_ready !== 1'h1 && w < 3000) begin @(negedge clk); w++; end
        if (w >= 3000) give_up("byte not taken");
        @(posedge clk);
    endtask

    // kind 0 start, 1 window, 2 overhead mark, 3 idle; checks n reference cycles
    task automatic stream(input int kind, input int n);
        int w, pos, blk, p, gexp;
        logic e;
        w = 0;
        pos = 0;
        blk = 0;
        p = 0;
        gexp = 0;
        @(negedge rc);
        if (kind != 3) begin
            while (mk_w !== 1'h1 && w < 5000) begin @(negedge rc); w++; end
            if (kind == 1) while (mk_w !== 1'h0 && w < 5000) begin @(negedge rc); w++; end
            if (w >= 5000) give_up("no frame marker");
        end
        if (kind == 2) pos = 1;
        gcnt = 0;
        for (int i = 0; i < n; i++) begin
            case (kind)
                0:       e = (pos == 0 && blk == 0);
                1:       e = (pos != 0);
                2:       e = (pos != 0 && p == 0);
                default: e = 1'h0;
            endcase
            cmp(mk_w, e);
            cmp(tx_payload_valid_out, cfg.inv_valid);
            cmp(tx_payload_bit_out, cfg.inv_bit);
            if (kind == 2) gexp += e;
            else if (kind != 3) gexp += (pos != 0);
            if (pos != 0) p = (p + 1) % TFO_FRAC_PERIOD;
            pos = (pos + 1) % TFO_BLOCK_BITS;
            if (pos == 0) blk = (blk + 1) % TFO_BLOCKS;
            @(negedge rc);
        end
        cmp32(gcnt, gexp);
    endtask

    tfo_mode_e md[4] = '{TFO_MODE_NONFRAC, TFO_MODE_EXT, TFO_MODE_FLEX, TFO_MODE_NONFRAC};
    tfo_ref_e  rf[4] = '{TFO_REF_TXIN, TFO_REF_TXOUT, TFO_REF_RXOUT, TFO_REF_RXLN};

    // main sequence
    initial begin
        err_count = 0;
        n_tests = 0;
        gcnt = 0;
        rst = 1'h1;
        run = 1'h0;
        cfg = mk(1'h0, TFO_MODE_NONFRAC, TFO_FN_WINDOW, 1'h0, 1'h0, 1'h0);
        ref_sel = TFO_REF_TXIN;
        ref_clk_invert = 1'h0;
        pay_data = 8'h00;
        pay_valid = 1'h0;
        repeat (20) @(negedge clk);
        rst = 1'h0;
        // window under every reference clock, with edge and pin inversion mixed in
        for (int r = 0; r < 4; r++) begin
            restart(mk(1'h1, md[r], TFO_FN_WINDOW, r[1], 1'h0, 1'h0), rf[r], r[0]);
            stream(1, 170);
        end
        // internal fractional overhead mark over eight blocks, eighty-four full pattern periods
        restart(mk(1'h1, TFO_MODE_INT, TFO_FN_START, 1'h0, 1'h1, 1'h1), TFO_REF_TXIN, 1'h0);
        stream(2, 680);
        // start pulse over a whole frame, inverted pin
        restart(mk(1'h1, TFO_MODE_NONFRAC, TFO_FN_START, 1'h1, 1'h0, 1'h0), TFO_REF_TXIN, 1'h0);
        stream(0, 4770);
        // pins off, then a mode that drives nothing
        restart(mk(1'h0, TFO_MODE_EXT, TFO_FN_WINDOW, 1'h1, 1'h1, 1'h1), TFO_REF_RXOUT, 1'h0);
        stream(3, 100);
        restart(mk(1'h1, TFO_MODE_PLCP, TFO_FN_WINDOW, 1'h0, 1'h1, 1'h0), TFO_REF_TXIN, 1'h0);
        stream(3, 100);
        // flex payload: four bytes through a gapped enable, inverted valid and bit
        restart(mk(1'h1, TFO_MODE_FLEX, TFO_FN_WINDOW, 1'h0, 1'h1, 1'h1), TFO_REF_TXIN, 1'h0);
        put_byte(8'hA5);
        repeat (40) @(negedge clk);
        run = 1'h1;
        put_byte(8'hC3);
        put_byte(8'h1E);
        put_byte(8'h7F);
        @(negedge clk);
        pay_valid = 1'h0;
        for (int w = 0; w < 20000 && nbits < 32; w++) @(negedge clk);
        if (nbits < 32) give_up("payload bits");
        cmp32(word, 32'hA5C3_1E7F);
        run = 1'h0;
        report_and_stop();
    end
endmodule
